// ==== common/dacif_consts.vh ====
// constants for the converter interrupt flag unit
// Functional notes
// - control bit 3 at 1 lets a status read clear error flags 3..0 and their interrupt; 0 blocks clearing.
// - 2-bit drift threshold: 00 pos 1/5, 01 pos 2/4, 10 pos 3, 11 off.
// - enable bit 7 gates the acquisition module B interrupt.
// - enable bit 6 gates the acquisition module A interrupt.
// - enable bit 5 gates the memory autoload completion interrupt.
// - enable bit 4 gates the link auto-calibration interrupt.
// - enable bit 3 gates the memory load error interrupt.
// - enable bit 2 gates the input clock sampling error interrupt.
// - enable bit 1 gates the link parity or bit-error interrupt.
// - enable bit 0 gates the converter clock drift interrupt.
// - status bit 7 shows acquisition module B ready, read only.
// - status bit 6 shows acquisition module A ready, read only.
// - status bit 5 shows memory autoload done, read only.
// - status bit 4 shows link auto-calibration done, read only.
// - status bit 3 is 1 after a memory load error, else 0.
// - status bit 2 is 1 after an input clock sampling error, else 0.
// - status bit 1 is 1 after a link parity or bit error, else 0.
// - status bit 0 is 1 after a converter clock drift error, else 0.
`ifndef DACIF_CONSTS_VH
`define DACIF_CONSTS_VH

`define DACIF_ADDR_W 5
`define DACIF_CTRL_OFS 5'h0b
`define DACIF_ENAB_OFS 5'h0c
`define DACIF_FLAG_OFS 5'h0d

`define DACIF_CTRL_RST 4'h0
`define DACIF_ENAB_RST 8'h00
`define DACIF_CTRL_CLR_BIT 3
`define DACIF_CTRL_THR_MSB 1
`define DACIF_CTRL_THR_LSB 0

`define DACIF_THR_SMALL 2'h0
`define DACIF_THR_LARGE 2'h1
`define DACIF_THR_MAX 2'h2
`define DACIF_THR_OFF 2'h3
`define DACIF_POS_SMALL_A 3'h1
`define DACIF_POS_SMALL_B 3'h5
`define DACIF_POS_LARGE_A 3'h2
`define DACIF_POS_LARGE_B 3'h4
`define DACIF_POS_MAX 3'h3

`define DACIF_BIT_ACQB 7
`define DACIF_BIT_ACQA 6
`define DACIF_BIT_AUTOLOAD 5
`define DACIF_BIT_CALIB 4
`define DACIF_BIT_LOADERR 3
`define DACIF_BIT_CLKSAMP 2
`define DACIF_BIT_LINKERR 1
`define DACIF_BIT_DRIFT 0
`define DACIF_NUM_ERR 4

`define DACIF_HDR_LAST 5'h07
`define DACIF_FRAME_LAST 5'h0f
`define DACIF_FRAME_DONE 5'h10

`endif

// ==== rtl/dacif_flag_cell.v ====
// sticky error flag cell, set wins over clear
`timescale 1ns/1ps
module dacif_flag_cell (
  // clock and reset
  input wire core_clk,
  input wire arst_n,
  // control
  input wire setEvt,
  input wire clrReq,
  // state
  output wire flagOut
);

  reg flag_reg;
  wire flag_next;

  // an event in the clearing cycle survives the clear
  assign flag_next = setEvt | (flag_reg & ~clrReq);

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign flagOut = flag_reg;

endmodule // dacif_flag_cell

// ==== rtl/dacif_irq_unit.v ====
// interrupt flag unit with its serial register port
`timescale 1ns/1ps
`include "dacif_consts.vh"
module dacif_irq_unit #(
  parameter NUM_ERR = `DACIF_NUM_ERR
) (
  // clock and reset
  input wire core_clk,
  input wire arst_n,
  // serial register port
  input wire spiClk,
  input wire spiCsN,
  input wire spiDataIn,
  output wire spiDataOut,
  output wire spiDataOutEn,
  // status sources, levels
  input wire acqBReady,
  input wire acqAReady,
  input wire autoloadDone,
  input wire calibDone,
  // error sources, one-cycle events
  input wire loadErrorEvt,
  input wire inputClockSampleErrEvt,
  input wire linkErrorEvt,
  // converter clock monitor position
  input wire [2:0] driftPosition,
  // interrupt
  output wire irqOut
);

  // serial frame state
  reg sclkPrev_reg;
  reg [4:0] bitCnt_reg;
  reg [4:0] bitCnt_next;
  reg [7:0] rxShift_reg;
  reg [7:0] rxShift_next;
  reg [7:0] txShift_reg;
  reg [7:0] txShift_next;
  reg isRead_reg;
  reg isRead_next;
  reg [4:0] addr_reg;
  reg [4:0] addr_next;
  reg loadPend_reg;
  reg loadPend_next;
  wire sclkRise;
  wire sclkFall;
  reg regWrite;
  reg [7:0] regWrData;

  // registers
  reg [3:0] ctrl_reg;
  reg [3:0] ctrl_next;
  reg [7:0] enab_reg;
  reg [7:0] enab_next;
  reg [3:0] ready_reg;
  reg irq_reg;
  wire irq_next;
  reg [7:0] rdData;

  // flags
  wire clearEnable;
  wire [1:0] driftThreshold;
  reg driftHit;
  wire [NUM_ERR-1:0] errEvt;
  wire [NUM_ERR-1:0] errFlags;
  wire flagRead;
  wire flagClear;
  wire [7:0] flagView;
  wire [7:0] gatedFlags;

  // inputs are synchronous, so a single delayed copy gives the edges
  assign sclkRise = ~spiCsN & spiClk & ~sclkPrev_reg;
  assign sclkFall = ~spiCsN & ~spiClk & sclkPrev_reg;

  // frame: read bit, two unused bits, 5-bit address, then 8 data bits
  always @* begin
    bitCnt_next = bitCnt_reg;
    rxShift_next = rxShift_reg;
    txShift_next = txShift_reg;
    isRead_next = isRead_reg;
    addr_next = addr_reg;
    loadPend_next = 1'b0;
    regWrite = 1'b0;
    regWrData = {rxShift_reg[6:0], spiDataIn};
    if (spiCsN) begin
      bitCnt_next = 5'h00;
      isRead_next = 1'b0;
    end else begin
      if (sclkRise && (bitCnt_reg != `DACIF_FRAME_DONE)) begin
        rxShift_next = {rxShift_reg[6:0], spiDataIn};
        bitCnt_next = bitCnt_reg + 5'h01;
        if (bitCnt_reg == `DACIF_HDR_LAST) begin
          addr_next = {rxShift_reg[3:0], spiDataIn};
          isRead_next = rxShift_reg[6];
          loadPend_next = rxShift_reg[6];
        end
        if ((bitCnt_reg == `DACIF_FRAME_LAST) && !isRead_reg) begin
          regWrite = 1'b1;
        end
      end
      if (loadPend_reg) begin
        txShift_next = rdData;
      end else if (sclkFall && isRead_reg && (bitCnt_reg > `DACIF_HDR_LAST + 5'h01)) begin
        txShift_next = {txShift_reg[6:0], 1'b0};
      end
    end
  end

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sclkPrev_reg <= 1'b0;
      bitCnt_reg <= 5'h00;
      rxShift_reg <= 8'h00;
      txShift_reg <= 8'h00;
      isRead_reg <= 1'b0;
      addr_reg <= 5'h00;
      loadPend_reg <= 1'b0;
    end else begin
      sclkPrev_reg <= spiClk;
      bitCnt_reg <= bitCnt_next;
      rxShift_reg <= rxShift_next;
      txShift_reg <= txShift_next;
      isRead_reg <= isRead_next;
      addr_reg <= addr_next;
      loadPend_reg <= loadPend_next;
    end
  end

  // the data line is driven only while a read frame is in its data phase
  assign spiDataOut = txShift_reg[7];
  assign spiDataOutEn = ~spiCsN & isRead_reg & (bitCnt_reg > `DACIF_HDR_LAST);

  // register writes; the status register ignores writes
  always @* begin
    ctrl_next = ctrl_reg;
    enab_next = enab_reg;
    if (regWrite) begin
      case (addr_reg)
        `DACIF_CTRL_OFS: begin
          ctrl_next = {regWrData[`DACIF_CTRL_CLR_BIT], 1'b0, regWrData[1:0]};
        end
        `DACIF_ENAB_OFS: begin
          enab_next = regWrData;
        end
        default: begin
          ctrl_next = ctrl_reg;
        end
      endcase
    end
  end

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg <= `DACIF_CTRL_RST;
      enab_reg <= `DACIF_ENAB_RST;
      ready_reg <= 4'h0;
    end else begin
      ctrl_reg <= ctrl_next;
      enab_reg <= enab_next;
      ready_reg <= {acqBReady, acqAReady, autoloadDone, calibDone};
    end
  end

  assign clearEnable = ctrl_reg[`DACIF_CTRL_CLR_BIT];
  assign driftThreshold = ctrl_reg[`DACIF_CTRL_THR_MSB:`DACIF_CTRL_THR_LSB];

  // exact positions only: each code but 11 (off) watches its own drift distance
  always @* begin
    case (driftThreshold)
      `DACIF_THR_SMALL: begin
        driftHit = (driftPosition == `DACIF_POS_SMALL_A) || (driftPosition == `DACIF_POS_SMALL_B);
      end
      `DACIF_THR_LARGE: begin
        driftHit = (driftPosition == `DACIF_POS_LARGE_A) || (driftPosition == `DACIF_POS_LARGE_B);
      end
      `DACIF_THR_MAX: begin
        driftHit = (driftPosition == `DACIF_POS_MAX);
      end
      default: begin
        driftHit = 1'b0;
      end
    endcase
  end

  assign errEvt = {loadErrorEvt, inputClockSampleErrEvt, linkErrorEvt, driftHit};

  // clearing happens when the status word is captured for shifting out
  assign flagRead = loadPend_reg && (addr_reg == `DACIF_FLAG_OFS);
  assign flagClear = flagRead & clearEnable;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_ERR; gi = gi + 1) begin : g_err
      dacif_flag_cell u_flag (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .setEvt(errEvt[gi]),
        .clrReq(flagClear),
        .flagOut(errFlags[gi])
      );
    end
  endgenerate

  assign flagView = {ready_reg, errFlags};

  // per-source gating; enable bit n masks status bit n
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_gate
      assign gatedFlags[gi] = flagView[gi] & enab_reg[gi];
    end
  endgenerate

  assign irq_next = |gatedFlags;

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  assign irqOut = irq_reg;

  // read mux; unmapped addresses read as zero
  always @* begin
    case (addr_reg)
      `DACIF_CTRL_OFS: begin
        rdData = {4'h0, ctrl_reg};
      end
      `DACIF_ENAB_OFS: begin
        rdData = enab_reg;
      end
      `DACIF_FLAG_OFS: begin
        rdData = flagView;
      end
      default: begin
        rdData = 8'h00;
      end
    endcase
  end

endmodule // dacif_irq_unit

// ==== tb/dacif_irq_asserts.sv ====
// port checks for the interrupt flag unit
`timescale 1ns/1ps
module dacif_irq_asserts (
  // clock and reset
  input wire core_clk,
  input wire arst_n,
  // serial port
  input wire spiClk,
  input wire spiCsN,
  input wire spiDataOut,
  input wire spiDataOutEn,
  // sources and interrupt
  input wire acqBReady,
  input wire acqAReady,
  input wire autoloadDone,
  input wire calibDone,
  input wire loadErrorEvt,
  input wire inputClockSampleErrEvt,
  input wire linkErrorEvt,
  input wire [2:0] driftPosition,
  input wire irqOut
);
  // no interrupt can exist before some source was ever active
  reg seen_reg;
  wire rdyAny = acqBReady | acqAReady | autoloadDone | calibDone;
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) seen_reg <= 1'b0;
    else if (rdyAny | loadErrorEvt | inputClockSampleErrEvt | linkErrorEvt | (|driftPosition)) seen_reg <= 1'b1;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  property p_rst; $rose(arst_n) |-> !irqOut && !spiDataOut; endproperty
  a_rst: assert property (p_rst) else $error("output high after reset");
  property p_quiet; !seen_reg |-> !irqOut; endproperty
  a_quiet: assert property (p_quiet) else $error("irq without cause");
  property p_rise; $rose(irqOut) |-> $past(seen_reg); endproperty
  a_rise: assert property (p_rise) else $error("irq rose early");
  // a flag only drops through a frame or a ready going low
  property p_fell; $fell(irqOut) |-> !$past(spiCsN, 2) || $past(rdyAny, 3); endproperty
  a_fell: assert property (p_fell) else $error("irq fell without cause");
  property p_encs; spiCsN |-> !spiDataOutEn; endproperty
  a_encs: assert property (p_encs) else $error("driving while deselected");
  property p_hold; spiCsN && $past(spiCsN) |-> $stable(spiDataOut); endproperty
  a_hold: assert property (p_hold) else $error("data moved outside frame");
  property p_enrise; $rose(spiDataOutEn) |-> $past(spiClk) && !$past(spiCsN, 8); endproperty
  a_enrise: assert property (p_enrise) else $error("drive began off a rising clock");
  property p_enkeep; spiDataOutEn && !spiCsN |=> spiDataOutEn || spiCsN; endproperty
  a_enkeep: assert property (p_enkeep) else $error("drive dropped in frame");
endmodule // dacif_irq_asserts
bind dacif_irq_unit dacif_irq_asserts dacif_irq_asserts_i (
  .core_clk(core_clk),
  .arst_n(arst_n),
  .spiClk(spiClk),
  .spiCsN(spiCsN),
  .spiDataOut(spiDataOut),
  .spiDataOutEn(spiDataOutEn),
  .acqBReady(acqBReady),
  .acqAReady(acqAReady),
  .autoloadDone(autoloadDone),
  .calibDone(calibDone),
  .loadErrorEvt(loadErrorEvt),
  .inputClockSampleErrEvt(inputClockSampleErrEvt),
  .linkErrorEvt(linkErrorEvt),
  .driftPosition(driftPosition),
  .irqOut(irqOut)
);

// ==== tb/dacif_host_model.sv ====
// serial host that runs register frames
`timescale 1ns/1ps
module dacif_host_model (
  // clock
  input wire core_clk,
  // serial port
  output reg spiClk = 1'b0,
  output reg spiCsN = 1'b1,
  output reg spiDataIn = 1'b0,
  input wire spiDataOut,
  input wire spiDataOutEn
);
  // long phases leave room for the port's delayed-copy edge detection
  task xfer(input [15:0] w, output [7:0] r);
    integer i;
    begin
      r = 8'h00;
      @(posedge core_clk);
      spiCsN <= 1'b0;
      for (i = 15; i >= 0; i = i - 1) begin
        @(posedge core_clk);
        spiClk <= 1'b0;
        spiDataIn <= w[i];
        repeat (6) @(posedge core_clk);
        spiClk <= 1'b1;
        // an undriven line reads inverted, so a late enable is caught
        r = {r[6:0], spiDataOutEn ? spiDataOut : ~spiDataOut};
        repeat (3) @(posedge core_clk);
      end
      @(posedge core_clk);
      spiClk <= 1'b0;
      repeat (6) @(posedge core_clk);
      spiCsN <= 1'b1;
      spiDataIn <= ~spiDataIn;
      @(posedge core_clk);
    end
  endtask
endmodule // dacif_host_model

// ==== tb/dac_interrupt_flag_unit_bench.sv ====
// self-checking bench for the interrupt flag unit
`timescale 1ns/1ps
module dac_interrupt_flag_unit_bench;
  reg core_clk = 1'b0;
  reg arst_n = 1'b0;
  reg [3:0] rdy = 4'h0;
  reg [2:0] evt = 3'h0;
  reg [2:0] driftPosition = 3'h0;
  wire acqBReady, acqAReady, autoloadDone, calibDone, loadErrorEvt, inputClockSampleErrEvt, linkErrorEvt;
  wire spiClk, spiCsN, spiDataIn, spiDataOut, spiDataOutEn, irqOut;
  integer num_errors = 0, compares = 0, ctrl = 0, en = 0, err = 0, b, k;
  reg [7:0] rd;
  assign {acqBReady, acqAReady, autoloadDone, calibDone} = rdy;
  assign {loadErrorEvt, inputClockSampleErrEvt, linkErrorEvt} = evt;
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  dacif_irq_unit dacif_irq_unit_i (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .spiClk(spiClk),
    .spiCsN(spiCsN),
    .spiDataIn(spiDataIn),
    .spiDataOut(spiDataOut),
    .spiDataOutEn(spiDataOutEn),
    .acqBReady(acqBReady),
    .acqAReady(acqAReady),
    .autoloadDone(autoloadDone),
    .calibDone(calibDone),
    .loadErrorEvt(loadErrorEvt),
    .inputClockSampleErrEvt(inputClockSampleErrEvt),
    .linkErrorEvt(linkErrorEvt),
    .driftPosition(driftPosition),
    .irqOut(irqOut)
  );
  dacif_host_model dacif_host_model_i (
    .core_clk(core_clk),
    .spiClk(spiClk),
    .spiCsN(spiCsN),
    .spiDataIn(spiDataIn),
    .spiDataOut(spiDataOut),
    .spiDataOutEn(spiDataOutEn)
  );
  task chk(input [7:0] got, input integer exp);
    begin
      compares = compares + 1;
      if (got !== exp[7:0]) begin
        num_errors = num_errors + 1;
        $display("mismatch at %0t: got %h want %h", $time, got, exp[7:0]);
      end
    end
  endtask
  task wr(input [4:0] a, input [7:0] d);
    begin
      dacif_host_model_i.xfer({3'b000, a, d}, rd);
      if (a == 5'h0b) ctrl = d & 8'h0b;
      if (a == 5'h0c) en = d;
    end
  endtask
  task rdreg(input [4:0] a);
    begin
      dacif_host_model_i.xfer({3'b100, a, 8'h00}, rd);
      chk(rd, a == 5'h0b ? ctrl : a == 5'h0c ? en : a == 5'h0d ? {rdy, err[3:0]} : 0);
      if (a == 5'h0d && ctrl[3]) err = 0;
    end
  endtask
  task irqchk;
    begin
      repeat (3) @(posedge core_clk);
      chk({7'h00, irqOut}, ({rdy, err[3:0]} & en) != 0);
    end
  endtask
  task setsrc(input integer s);
    begin
      @(posedge core_clk);
      if (s > 3) rdy[s - 4] <= 1'b1;
      else if (s > 0) evt[s - 1] <= 1'b1;
      else driftPosition <= 3'h1;
      @(posedge core_clk);
      evt <= 3'h0;
      driftPosition <= 3'h0;
      if (s < 4) err = err | (1 << s);
    end
  endtask
  function match(input [1:0] c, input [2:0] p);
    match = (c == 0 && (p == 1 || p == 5)) || (c == 1 && (p == 2 || p == 4)) || (c == 2 && p == 3);
  endfunction
  task end_sim;
    begin
      $display("compares %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  initial begin
    k = $urandom(32'h192a);
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
    rdreg(5'h0b);
    rdreg(5'h0c);
    rdreg(5'h0d);
    rdreg(5'h1e);
    irqchk;
    $display("test reset done");
    for (k = 0; k < 4; k = k + 1) begin
      wr(5'h0b, $urandom);
      rdreg(5'h0b);
      wr(5'h0c, $urandom);
      rdreg(5'h0c);
    end
    @(posedge core_clk) rdy <= $urandom;
    // status is read only
    wr(5'h0d, 8'hff);
    rdreg(5'h0d);
    // unmapped writes must not alias onto the control register
    wr(5'h1e, 8'hff);
    rdreg(5'h1e);
    rdreg(5'h0b);
    irqchk;
    $display("test registers done");
    for (b = 0; b < 8; b = b + 1) begin
      @(posedge core_clk) rdy <= 4'h0;
      wr(5'h0b, 8'h08);
      rdreg(5'h0d);
      wr(5'h0c, 8'hff ^ (8'h01 << b));
      setsrc(b);
      irqchk;
      wr(5'h0c, 8'h01 << b);
      irqchk;
      rdreg(5'h0d);
      irqchk;
    end
    $display("test sources done");
    for (k = 0; k < 32; k = k + 1) begin
      wr(5'h0b, {6'h02, k[4:3]});
      @(posedge core_clk) driftPosition <= k[2:0];
      @(posedge core_clk) driftPosition <= 3'h0;
      if (match(k[4:3], k[2:0])) err = err | 1;
      rdreg(5'h0d);
    end
    $display("test drift done");
    wr(5'h0b, 8'h00);
    setsrc(3);
    rdreg(5'h0d);
    rdreg(5'h0d);
    $display("test hold done");
    // mid-run reset drops sticky flags and register contents
    @(posedge core_clk) arst_n <= 1'b0;
    err = 0;
    ctrl = 0;
    en = 0;
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
    rdreg(5'h0b);
    rdreg(5'h0c);
    rdreg(5'h0d);
    irqchk;
    $display("test mid reset done");
    end_sim;
  end
  initial begin
    #600000;
    num_errors = num_errors + 1;
    end_sim;
  end
endmodule // dac_interrupt_flag_unit_bench
